// >>> logic/wrxc_regs.svh
// Purpose: constants for the wireless receiver mode and status control
// Assumes: 100 MHz clock
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef WRXC_REGS_SVH
`define WRXC_REGS_SVH

`define WRXC_CLK_HZ 100000000
`define WRXC_TICK_US 1000
`define WRXC_TICK_CYC ((`WRXC_CLK_HZ / 1000000) * `WRXC_TICK_US)
`define WRXC_TERM_HI_S 180
`define WRXC_TERM_LO_S 7
`define WRXC_TERM_HI_MS (`WRXC_TERM_HI_S * 1000)
`define WRXC_TERM_LO_MS (`WRXC_TERM_LO_S * 1000)
`define WRXC_ERR_FAST_MS 30
`define WRXC_ERR_SLOW_MS 250
`define WRXC_HDR_EPT 8'h02
`define WRXC_HDR_CHARGE 8'h05
`define WRXC_HDR_ERROR 8'h03
`define WRXC_ERR_OVP 8'h80
`define WRXC_ERR_HIGH 8'hF0
`define WRXC_CS_PAYLOAD 8'h64
`define WRXC_EPT_UNKNOWN 8'h00
`define WRXC_EPT_CHARGED 8'h01
`define WRXC_EPT_FAULT 8'h02
`define WRXC_EPT_OVERTEMP 8'h03
`define WRXC_EPT_OVERCUR 8'h05

`endif

// >>> logic/wrxc_pkg.sv
// Purpose: types for the wireless receiver mode and status control
// Assumes: nothing
// Notes: mode codes follow the two mode-select pins {a,b}
`default_nettype none
package wrxc_pkg;
	typedef enum logic [1:0] {
		MODE_ADAPTER = 2'h0,
		MODE_NO_COMM_LIMIT = 2'h1,
		MODE_BOOST_BACK = 2'h2,
		MODE_ALL_OFF = 2'h3
	} wrxc_mode_type;

	typedef enum logic [2:0] {
		TERM_IDLE = 3'h1,
		TERM_HIGH = 3'h2,
		TERM_LOW = 3'h4
	} wrxc_term_type;
endpackage : wrxc_pkg
`default_nettype wire

// >>> logic/wrxc_tick.sv
// Purpose: millisecond tick enable from the system clock
// Assumes: clk at 100 MHz
// Notes: one-cycle pulse every PERIOD cycles
`timescale 1ns/100ps
`default_nettype none
module wrxc_tick #(
	parameter int PERIOD = 100000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// tick out
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} wrxc_tick_state_type;

	wrxc_tick_state_type state_ff;
	wrxc_tick_state_type nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.tick = 1'b0;
		if (state_ff.cnt == 32'(PERIOD - 1))
		begin
			nxt_state.cnt = 32'h0000_0000;
			nxt_state.tick = 1'b1;
		end
		else
		begin
			nxt_state.cnt = state_ff.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign tick = state_ff.tick;
endmodule : wrxc_tick
`default_nettype wire

// >>> logic/wrxc_ctrl.sv
// Purpose: mode decode, adapter switch steering, charge-complete timing,
//          overvoltage error pacing and end-power-transfer reason choice
// Assumes: all inputs synchronous to clk; analog comparators outside
// Notes: packets leave as a request held until ack, with header and payload;
//        framing and modulation live elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "wrxc_regs.svh"

// Behaviour
// - charge-complete report uses header 0x05
// - report never requests power stop
// - between thresholds repeat every 3 minutes
// - below lower threshold repeat every 7s
// - first report after full deglitch interval
// - above target errors 30ms, then 250ms
// - overvoltage disables regulator, requests lower voltage
// - unconnected selects read low, adapter default
// - 00: adapter control, comm limit on
// - 01: comm limit off, wireless on
// - 10: switch on, wireless off, boost-back
// - 11: both paths off, no output
// - adapter absent keeps switch enable off
// - adapter above 3.6V: switch on, wireless off
// - wired path has priority over wireless
// - end-power-transfer header 0x02 with reason
// - reason 0x00 when adapter above 3.6V
// - reason 0x01 for control high or select a high
// - reason 0x02 for overtemp die or resistor
// - reason 0x03 for thermistor window faults
// - never 0x04; 0x05 only termination variant
// - never 0x07 nor undefined reasons
// - reason 0x05 at full limit or 120%
// - lower threshold fixed 40mA, upper external
module wrxc_ctrl #(
	parameter int TICK_CYC = `WRXC_TICK_CYC,
	parameter int TERM_HI_MS = `WRXC_TERM_HI_MS,
	parameter int TERM_LO_MS = `WRXC_TERM_LO_MS,
	parameter int ERR_FAST_MS = `WRXC_ERR_FAST_MS,
	parameter int ERR_SLOW_MS = `WRXC_ERR_SLOW_MS,
	parameter bit TERM_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// mode pins, low when unconnected
	input wire logic mode_select_a,
	input wire logic mode_select_b,
	// adapter sensing
	input wire logic adapter_above_detect,
	// output current comparators
	input wire logic iout_below_upper_term,
	input wire logic iout_below_lower_term,
	input wire logic iout_over_overcur,
	// rectifier comparators
	input wire logic rectified_node_above_target,
	input wire logic rectified_node_above_ovp,
	// fault sensing
	input wire logic thermistor_control_high,
	input wire logic thermistor_control_low,
	input wire logic thermistor_out_of_window,
	input wire logic junction_over_temp,
	input wire logic current_limit_set_low,
	// packet request toward the modulator
	output logic pkt_req,
	output logic [7:0] pkt_header,
	output logic [7:0] pkt_payload,
	input wire logic pkt_ack,
	// power path controls
	output logic adapter_switch_en,
	output logic wireless_power_en,
	output logic boost_back_mode,
	output logic comm_limit_en,
	output logic regulator_en,
	output logic power_transfer_ended
);
	typedef struct packed {
		logic [31:0] term_ms;
		logic [31:0] err_ms;
		logic err_active;
		logic err_fast;
		logic ovp_seen;
		wrxc_pkg::wrxc_term_type term;
		logic pend_cs;
		logic pend_err;
		logic pend_ept;
		logic [7:0] ept_reason;
		logic ended;
		logic req;
		logic [7:0] hdr;
		logic [7:0] pay;
		logic sw_en;
		logic wl_en;
		logic boost;
		logic climit;
		logic reg_en;
	} wrxc_state_type;

	wrxc_state_type state_ff;
	wrxc_state_type nxt_state;
	wrxc_pkg::wrxc_mode_type mode;
	wrxc_pkg::wrxc_term_type cur_cond;
	logic tick;
	logic ept_hit;
	logic [7:0] ept_code;
	logic [31:0] term_limit;
	logic ept_legal;
	logic err_restart;

	wrxc_tick #(
		.PERIOD(TICK_CYC)
	) wrxc_tick_inst (
		.clk(clk),
		.rst(rst),
		.tick(tick)
	);

	// unconnected pins read low, giving adapter mode
	assign mode = wrxc_pkg::wrxc_mode_type'({mode_select_a, mode_select_b});

	// lower threshold compared outside at fixed 40mA
	always_comb
	begin
		if (iout_below_lower_term)
			cur_cond = wrxc_pkg::TERM_LOW;
		else if (iout_below_upper_term)
			cur_cond = wrxc_pkg::TERM_HIGH;
		else
			cur_cond = wrxc_pkg::TERM_IDLE;
	end

	assign term_limit = (cur_cond == wrxc_pkg::TERM_LOW) ? 32'(TERM_LO_MS) : 32'(TERM_HI_MS);

	// reason priority: most severe condition first
	always_comb
	begin
		ept_hit = 1'b1;
		ept_code = `WRXC_EPT_UNKNOWN;
		if (junction_over_temp || current_limit_set_low)
			ept_code = `WRXC_EPT_FAULT;
		else if (thermistor_out_of_window || thermistor_control_low)
			ept_code = `WRXC_EPT_OVERTEMP;
		else if (TERM_VARIANT && iout_over_overcur)
			ept_code = `WRXC_EPT_OVERCUR;
		else if (thermistor_control_high || mode_select_a)
			ept_code = `WRXC_EPT_CHARGED;
		else if (adapter_above_detect && mode == wrxc_pkg::MODE_ADAPTER)
			ept_code = `WRXC_EPT_UNKNOWN;
		// nothing else ends transfer, 0x04 and 0x07 never built
		else
			ept_hit = 1'b0;
	end

	// only reasons with a trigger may leave
	always_comb
	begin
		ept_legal = 1'b0;
		case (ept_code)
			`WRXC_EPT_UNKNOWN, `WRXC_EPT_CHARGED, `WRXC_EPT_FAULT, `WRXC_EPT_OVERTEMP:
				ept_legal = 1'b1;
			// over current exists only on the termination-capable build
			`WRXC_EPT_OVERCUR:
				ept_legal = TERM_VARIANT;
			default:
				ept_legal = 1'b0;
		endcase
	end

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.req = 1'b0;
		err_restart = 1'b0;

		case (mode)
			wrxc_pkg::MODE_ADAPTER:
			begin
				nxt_state.sw_en = adapter_above_detect;
				nxt_state.wl_en = !adapter_above_detect;
				nxt_state.boost = 1'b0;
				nxt_state.climit = 1'b1;
			end
			wrxc_pkg::MODE_NO_COMM_LIMIT:
			begin
				nxt_state.sw_en = 1'b0;
				nxt_state.wl_en = 1'b1;
				nxt_state.boost = 1'b0;
				nxt_state.climit = 1'b0;
			end
			wrxc_pkg::MODE_BOOST_BACK:
			begin
				nxt_state.sw_en = 1'b1;
				nxt_state.wl_en = 1'b0;
				nxt_state.boost = 1'b1;
				nxt_state.climit = 1'b0;
			end
			wrxc_pkg::MODE_ALL_OFF:
			begin
				nxt_state.sw_en = 1'b0;
				nxt_state.wl_en = 1'b0;
				nxt_state.boost = 1'b0;
				nxt_state.climit = 1'b0;
			end
			default:
			begin
				nxt_state.sw_en = 1'b0;
				nxt_state.wl_en = 1'b0;
				nxt_state.boost = 1'b0;
				nxt_state.climit = 1'b0;
			end
		endcase

		nxt_state.reg_en = !rectified_node_above_ovp && nxt_state.wl_en && !state_ff.ended;

		if (cur_cond != state_ff.term)
		begin
			nxt_state.term = cur_cond;
			nxt_state.term_ms = 32'h0000_0000;
		end
		else if (tick && cur_cond != wrxc_pkg::TERM_IDLE && TERM_VARIANT)
		begin
			if (state_ff.term_ms + 32'h0000_0001 >= term_limit)
			begin
				nxt_state.term_ms = 32'h0000_0000;
				nxt_state.pend_cs = 1'b1;
			end
			else
			begin
				nxt_state.term_ms = state_ff.term_ms + 32'h0000_0001;
			end
		end

		// error pacing: fast while above target, slow after
		if (rectified_node_above_target || rectified_node_above_ovp)
		begin
			if (!state_ff.err_fast)
			begin
				nxt_state.err_ms = 32'h0000_0000;
				nxt_state.pend_err = 1'b1;
				err_restart = 1'b1;
			end
			nxt_state.err_active = 1'b1;
			nxt_state.err_fast = 1'b1;
			nxt_state.ovp_seen = rectified_node_above_ovp;
		end
		else if (state_ff.err_fast)
		begin
			nxt_state.err_fast = 1'b0;
			nxt_state.err_ms = 32'h0000_0000;
			err_restart = 1'b1;
		end
		// a restart owns this cycle, so a coincident tick cannot shorten the gap
		if (tick && state_ff.err_active && !err_restart)
		begin
			if (state_ff.err_ms + 32'h0000_0001 >=
				(state_ff.err_fast ? 32'(ERR_FAST_MS) : 32'(ERR_SLOW_MS)))
			begin
				nxt_state.err_ms = 32'h0000_0000;
				nxt_state.pend_err = 1'b1;
			end
			else
			begin
				nxt_state.err_ms = state_ff.err_ms + 32'h0000_0001;
			end
		end

		if (ept_hit && ept_legal && !state_ff.ended)
		begin
			nxt_state.pend_ept = 1'b1;
			nxt_state.ept_reason = ept_code;
			nxt_state.ended = 1'b1;
		end
		else if (!ept_hit)
		begin
			nxt_state.ended = 1'b0;
		end

		// issue one packet at a time; end transfer first
		if (pkt_ack && state_ff.req)
		begin
			nxt_state.req = 1'b0;
		end
		else if (state_ff.req)
		begin
			nxt_state.req = 1'b1;
		end
		else if (nxt_state.pend_ept)
		begin
			nxt_state.pend_ept = 1'b0;
			nxt_state.req = 1'b1;
			nxt_state.hdr = `WRXC_HDR_EPT;
			nxt_state.pay = nxt_state.ept_reason;
		end
		else if (nxt_state.pend_err)
		begin
			// control error: negative value asks for lower voltage
			nxt_state.pend_err = 1'b0;
			nxt_state.req = 1'b1;
			nxt_state.hdr = `WRXC_HDR_ERROR;
			nxt_state.pay = nxt_state.ovp_seen ? `WRXC_ERR_OVP : `WRXC_ERR_HIGH;
		end
		else if (nxt_state.pend_cs)
		begin
			nxt_state.pend_cs = 1'b0;
			nxt_state.req = 1'b1;
			nxt_state.hdr = `WRXC_HDR_CHARGE;
			nxt_state.pay = `WRXC_CS_PAYLOAD;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= '0;
			state_ff.term <= wrxc_pkg::TERM_IDLE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// outputs straight from the state flops
	assign pkt_req = state_ff.req;
	assign pkt_header = state_ff.hdr;
	assign pkt_payload = state_ff.pay;
	assign adapter_switch_en = state_ff.sw_en;
	assign wireless_power_en = state_ff.wl_en;
	assign boost_back_mode = state_ff.boost;
	assign comm_limit_en = state_ff.climit;
	assign regulator_en = state_ff.reg_en;
	assign power_transfer_ended = state_ff.ended;
endmodule : wrxc_ctrl
`default_nettype wire

// >>> dv/wrxc_tx_model.sv
// Purpose: transmitter end of the packet link
// Assumes: one ack pulse per packet
// Notes: slow stretches the wait before ack
`timescale 1ns/100ps
`default_nettype none
module wrxc_tx_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// packet link
	input wire logic pkt_req,
	input wire logic [7:0] pkt_header,
	input wire logic [7:0] pkt_payload,
	output logic pkt_ack,
	// pacing and capture
	input wire logic slow,
	output logic got,
	output logic [7:0] hdr,
	output logic [7:0] pay
);
	logic [2:0] wait_ff;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{pkt_ack, got, wait_ff, hdr, pay} <= '0;
		end
		else
		begin
			got <= pkt_req && pkt_ack;
			if (pkt_req && pkt_ack)
			begin
				hdr <= pkt_header;
				pay <= pkt_payload;
			end
			// ack is one pulse, so a held request is never taken twice
			pkt_ack <= pkt_req && !pkt_ack && wait_ff >= (slow ? 3'h4 : 3'h0);
			wait_ff <= (pkt_req && !pkt_ack) ? wait_ff + 3'h1 : 3'h0;
		end
	end
endmodule : wrxc_tx_model
`default_nettype wire

// >>> dv/wrxc_ctrl_chk.sv
// Purpose: port checker for wrxc_ctrl
// Assumes: mode outputs follow one edge after inputs
// Notes: bound to every wrxc_ctrl
`timescale 1ns/100ps
`default_nettype none
module wrxc_ctrl_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// mode and sensing
	input wire logic mode_select_a,
	input wire logic mode_select_b,
	input wire logic adapter_above_detect,
	input wire logic rectified_node_above_ovp,
	// packet link
	input wire logic pkt_req,
	input wire logic [7:0] pkt_header,
	input wire logic [7:0] pkt_payload,
	input wire logic pkt_ack,
	// power path
	input wire logic adapter_switch_en,
	input wire logic wireless_power_en,
	input wire logic boost_back_mode,
	input wire logic comm_limit_en,
	input wire logic regulator_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_taken;
		pkt_req && pkt_ack;
	endsequence
	sequence s_waiting;
		pkt_req && !pkt_ack;
	endsequence
	chk_taken_drop: assert property (s_taken |=> !pkt_req)
		else $error("request stayed after ack");
	chk_req_hold: assert property (s_waiting |=> pkt_req && $stable(pkt_header)
		&& $stable(pkt_payload)) else $error("request changed before ack");
	chk_hdr_legal: assert property (pkt_req |-> pkt_header inside {8'h02, 8'h03, 8'h05})
		else $error("unknown packet header");
	chk_bad_reason: assert property (pkt_req && pkt_header == 8'h02 |->
		!(pkt_payload inside {8'h04, 8'h06, 8'h07})) else $error("forbidden reason");
	chk_all_off: assert property (mode_select_a && mode_select_b |=>
		!adapter_switch_en && !wireless_power_en) else $error("power in off mode");
	chk_boost_mode: assert property (mode_select_a && !mode_select_b |=>
		adapter_switch_en && boost_back_mode && !wireless_power_en) else $error("boost mode");
	chk_no_adapter: assert property (!mode_select_a && !mode_select_b &&
		!adapter_above_detect |=> !adapter_switch_en && comm_limit_en) else $error("no adapter");
	chk_wired_first: assert property (!mode_select_a && !mode_select_b &&
		adapter_above_detect |=> adapter_switch_en && !wireless_power_en) else $error("priority");
	chk_comm_off: assert property (!mode_select_a && mode_select_b |=>
		!comm_limit_en && !adapter_switch_en && !boost_back_mode) else $error("limit mode");
	chk_ovp_ldo: assert property (rectified_node_above_ovp |=> !regulator_en)
		else $error("regulator on in overvoltage");
endmodule : wrxc_ctrl_chk
bind wrxc_ctrl wrxc_ctrl_chk wrxc_ctrl_chk_inst (.clk, .rst, .mode_select_a, .mode_select_b,
	.adapter_above_detect, .rectified_node_above_ovp, .pkt_req, .pkt_header, .pkt_payload, .pkt_ack,
	.adapter_switch_en, .wireless_power_en, .boost_back_mode, .comm_limit_en, .regulator_en);
`default_nettype wire

// >>> dv/wrxc_ctrl_bench.sv
// Purpose: self-checking bench for wrxc_ctrl
// Assumes: 1 ms shortened to 10 cycles
// Notes: interval windows allow a tick of phase slack plus ack delay
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module wrxc_ctrl_bench;
	logic clk = 0, rst = 1, ma = 0, mb = 0, slow = 0;
	logic [7:0] flt = '0;
	logic [3:0] cur = '0;
	logic pkt_req, pkt_ack, got, sw, wl, bb, cl, reg_en, ended;
	logic [7:0] pkt_header, pkt_payload, hdr, pay;
	int fails = 0, check_count = 0, cyc = 0, n;
	wrxc_ctrl #(.TICK_CYC(10), .TERM_HI_MS(20), .TERM_LO_MS(5), .ERR_FAST_MS(3),
		.ERR_SLOW_MS(8)) wrxc_ctrl_inst (.clk, .rst, .mode_select_a(ma), .mode_select_b(mb),
		.adapter_above_detect(flt[0]), .thermistor_control_high(flt[1]),
		.thermistor_control_low(flt[2]), .thermistor_out_of_window(flt[3]),
		.junction_over_temp(flt[4]), .current_limit_set_low(flt[5]),
		.iout_over_overcur(flt[6]), .iout_below_upper_term(cur[0]),
		.iout_below_lower_term(cur[1]), .rectified_node_above_target(cur[2]), .rectified_node_above_ovp(cur[3]),
		.pkt_req, .pkt_header, .pkt_payload, .pkt_ack, .adapter_switch_en(sw),
		.wireless_power_en(wl), .boost_back_mode(bb), .comm_limit_en(cl),
		.regulator_en(reg_en), .power_transfer_ended(ended));
	wrxc_tx_model wrxc_tx_model_inst (.clk, .rst, .pkt_req, .pkt_header, .pkt_payload,
		.pkt_ack, .slow, .got, .hdr, .pay);
	initial
	begin
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			test_done();
		end
	end
	task automatic do_reset;
		rst = 1;
		repeat (3) @(negedge clk);
		rst = 0;
	endtask : do_reset
	task automatic wait_pkt(input logic [7:0] h);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (!(got === 1'b1 && hdr === h) && n < 600);
	endtask : wait_pkt
	task automatic t_modes;
		logic [2:0] m;
		for (int i = 0; i < 8; i++)
		begin
			m = i[2:0];
			do_reset();
			{ma, mb, flt[0]} = m;
			repeat (2) @(negedge clk);
			`CHK("switch", (m[2] & !m[1]) | (m[2:1] == 2'h0 & m[0]), sw)
			`CHK("wireless", !m[2] & (m[1] | !m[0]), wl)
			`CHK("boost", m[2] & !m[1], bb)
			`CHK("limit", m[2:1] == 2'h0, cl)
		end
		{ma, mb, flt} = '0;
		$display("modes done");
	endtask : t_modes
	task automatic t_reasons;
		logic [8:0] cond [9] = '{9'h001, 9'h002, 9'h100, 9'h010, 9'h020, 9'h008, 9'h004,
			9'h040, 9'h058};
		logic [7:0] why [9] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03, 8'h05, 8'h02};
		for (int i = 0; i < 9; i++)
		begin
			do_reset();
			slow = i[0];
			{ma, flt} = cond[i];
			wait_pkt(8'h02);
			`CHK("end seen", 1'b1, got)
			`CHK("reason", why[i], pay)
			`CHK("ended", 1'b1, ended)
		end
		{ma, flt, slow} = '0;
		$display("reasons done");
	endtask : t_reasons
	task automatic t_charge;
		do_reset();
		cur = 4'h1;
		repeat (150) @(negedge clk);
		cur = 4'h0;
		@(negedge clk);
		cur = 4'h1;
		wait_pkt(8'h05);
		`CHK("first high", 1'b1, n >= 188 && n <= 215)
		`CHK("report", 8'h64, pay)
		wait_pkt(8'h05);
		`CHK("repeat high", 1'b1, n >= 188 && n <= 215)
		`CHK("still on", 1'b0, ended)
		cur = 4'h3;
		wait_pkt(8'h05);
		`CHK("first low", 1'b1, n >= 38 && n <= 65)
		wait_pkt(8'h05);
		`CHK("repeat low", 1'b1, n >= 38 && n <= 65)
		cur = 4'h0;
		$display("charge done");
	endtask : t_charge
	task automatic t_overvolt;
		do_reset();
		cur = 4'h4;
		wait_pkt(8'h03);
		`CHK("above target", 8'hf0, pay)
		wait_pkt(8'h03);
		`CHK("fast pace", 1'b1, n >= 24 && n <= 36)
		cur = 4'h0;
		wait_pkt(8'h03);
		wait_pkt(8'h03);
		`CHK("slow pace", 1'b1, n >= 74 && n <= 86)
		cur = 4'h8;
		wait_pkt(8'h03);
		`CHK("ovp first", 8'h80, pay)
		wait_pkt(8'h03);
		`CHK("ovp report", 8'h80, pay)
		`CHK("regulator", 1'b0, reg_en)
		cur = 4'h0;
		$display("overvoltage done");
	endtask : t_overvolt
	initial
	begin
		do_reset();
		t_modes();
		t_reasons();
		t_charge();
		t_overvolt();
		test_done();
	end
endmodule : wrxc_ctrl_bench
`default_nettype wire
